// ### design/ctr16_pkg.sv
// Constants, types and mode decoding shared by the 16-bit counter unit
// Operation
// - Count is seen as separate upper and lower byte locations.
// - Upper byte location reads and writes reach the shared high-byte latch.
// - Reading the lower byte copies the counter's upper byte into the latch.
// - Writing the lower byte loads the upper byte from the latch simultaneously.
// - A full 16-bit read or write takes effect in one clock.
// - Three-bit clock select picks an internal or external tick source.
// - Clock select zero stops the counter and holds its value.
// - Counter stays readable and writable whether or not ticks run.
// - Processor write beats clear, increment or decrement in that cycle.
// - Each tick clears, increments or decrements as the mode dictates.
// - Counter steps by exactly one per tick, up or down, except for the clear at top in single slope.
// - An internal direction signal picks increment or decrement.
// - Internal clear forces every counter bit to zero.
// - Top indication when counter equals highest value of its sequence.
// - Zero_reached indication when counter equals zero.
// - Four-bit waveform mode, split over control A and B, sets sequence.
// - Overflow flag set at the mode's point and can request an interrupt.
// - One high-byte latch serves counter, compare and capture registers.
// - Compare upper bytes read directly, without touching the latch.
package ctr16_pkg;

    // --------------------------------------------------------------
    // Register locations on the 8-bit I/O port
    // --------------------------------------------------------------
    localparam int CTR16_AW = 4;
    localparam logic [3:0] CTR16_ADDR_CTL_A = 4'h0;
    localparam logic [3:0] CTR16_ADDR_CTL_B = 4'h1;
    localparam logic [3:0] CTR16_ADDR_CNT_LO = 4'h2;
    localparam logic [3:0] CTR16_ADDR_CNT_HI = 4'h3;
    localparam logic [3:0] CTR16_ADDR_CMPA_LO = 4'h4;
    localparam logic [3:0] CTR16_ADDR_CMPA_HI = 4'h5;
    localparam logic [3:0] CTR16_ADDR_CMPB_LO = 4'h6;
    localparam logic [3:0] CTR16_ADDR_CMPB_HI = 4'h7;
    localparam logic [3:0] CTR16_ADDR_CAP_LO = 4'h8;
    localparam logic [3:0] CTR16_ADDR_CAP_HI = 4'h9;
    localparam logic [3:0] CTR16_ADDR_FLAG = 4'hA;

    // --------------------------------------------------------------
    // Field positions and reset values
    // --------------------------------------------------------------
    localparam int CTR16_WGM_LO_POS = 0;
    localparam int CTR16_CS_POS = 0;
    localparam int CTR16_WGM_HI_POS = 3;
    localparam int CTR16_OVF_POS = 0;
    localparam logic [7:0] CTR16_BYTE_RST = 8'h00;
    localparam logic [15:0] CTR16_WORD_RST = 16'h0000;
    localparam logic [15:0] CTR16_MAX = 16'hFFFF;
    localparam logic [15:0] CTR16_TOP8 = 16'h00FF;
    localparam logic [15:0] CTR16_TOP9 = 16'h01FF;
    localparam logic [15:0] CTR16_TOP10 = 16'h03FF;

    // Prescaler wrap masks for divide by 8, 64, 256 and 1024
    localparam logic [9:0] CTR16_DIV8_MASK = 10'h007;
    localparam logic [9:0] CTR16_DIV64_MASK = 10'h03F;
    localparam logic [9:0] CTR16_DIV256_MASK = 10'h0FF;
    localparam logic [9:0] CTR16_DIV1024_MASK = 10'h3FF;

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef enum logic [1:0] {CTR16_OVF_AT_MAX, CTR16_OVF_AT_TOP, CTR16_OVF_AT_ZERO_REACHED} ctr16_ovf_e;
    typedef enum logic {CTR16_UP, CTR16_DOWN} ctr16_dir_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } ctr16_bus_s;

    typedef struct packed {
        logic dual;
        logic cap_is_top;
        ctr16_ovf_e ovf_at;
        logic [15:0] top;
    } ctr16_mode_s;

    // Waveform mode to sequence shape; mode 13 is reserved, run as normal
    function automatic ctr16_mode_s ctr16_decode(input logic [3:0] wgm, input logic [15:0] cmpa,
                                                 input logic [15:0] cap);
        ctr16_mode_s m;
        m = '{dual: 1'b0, cap_is_top: 1'b0, ovf_at: CTR16_OVF_AT_MAX, top: CTR16_MAX};
        case (wgm)
            4'h1, 4'h2, 4'h3: m = '{1'b1, 1'b0, CTR16_OVF_AT_ZERO_REACHED,
                                    (wgm == 4'h1) ? CTR16_TOP8 : (wgm == 4'h2) ? CTR16_TOP9 : CTR16_TOP10};
            4'h4: m.top = cmpa;
            4'h5, 4'h6, 4'h7: m = '{1'b0, 1'b0, CTR16_OVF_AT_TOP,
                                    (wgm == 4'h5) ? CTR16_TOP8 : (wgm == 4'h6) ? CTR16_TOP9 : CTR16_TOP10};
            4'h8, 4'hA: m = '{1'b1, 1'b1, CTR16_OVF_AT_ZERO_REACHED, cap};
            4'h9, 4'hB: m = '{1'b1, 1'b0, CTR16_OVF_AT_ZERO_REACHED, cmpa};
            4'hC: m = '{1'b0, 1'b1, CTR16_OVF_AT_MAX, cap};
            4'hE: m = '{1'b0, 1'b1, CTR16_OVF_AT_TOP, cap};
            4'hF: m = '{1'b0, 1'b0, CTR16_OVF_AT_TOP, cmpa};
            default: m.top = CTR16_MAX;
        endcase
        return m;
    endfunction : ctr16_decode

endpackage : ctr16_pkg

// ### design/ctr16_tick_sel.sv
// Clock select: prescaler and synchronised external pin edge detection
`timescale 1ns/100ps
module ctr16_tick_sel
    import ctr16_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] clock_select_field,
    input wire logic ext_clk_pin,
    output logic timer_tick
);

    logic [9:0] presc;
    logic [9:0] next_presc;
    logic [2:0] ext_sync;
    logic [2:0] next_ext_sync;

    // ----------------------------------------------------------
    // Prescaler and pin sampling
    // ----------------------------------------------------------
    // Free-running prescaler; pin sampled twice before edge logic
    always_comb
    begin
        next_presc = presc + 10'h001;
        next_ext_sync = {ext_sync[1:0], ext_clk_pin};
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            presc <= 10'h000;
            ext_sync <= 3'h0;
        end
        else
        begin
            presc <= next_presc;
            ext_sync <= next_ext_sync;
        end
    end

    // ----------------------------------------------------------
    // Tick selection
    // ----------------------------------------------------------
    // Edge test reads stages 1 and 2 only, never the first stage
    always_comb
    begin
        case (clock_select_field)
            3'h1: timer_tick = 1'b1;
            3'h2: timer_tick = (presc & CTR16_DIV8_MASK) == CTR16_DIV8_MASK;
            3'h3: timer_tick = (presc & CTR16_DIV64_MASK) == CTR16_DIV64_MASK;
            3'h4: timer_tick = (presc & CTR16_DIV256_MASK) == CTR16_DIV256_MASK;
            3'h5: timer_tick = presc == CTR16_DIV1024_MASK;
            3'h6: timer_tick = ext_sync[2] & ~ext_sync[1];
            3'h7: timer_tick = ~ext_sync[2] & ext_sync[1];
            default: timer_tick = 1'b0;
        endcase
    end

endmodule : ctr16_tick_sel

// ### design/ctr16_count_core.sv
// Bidirectional counter with load, clear and top/zero_reached detection
`timescale 1ns/100ps
module ctr16_count_core
    import ctr16_pkg::*;
#(
    parameter int WIDTH = 16
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    input wire logic [WIDTH-1:0] top,
    input wire logic dual,
    output logic [WIDTH-1:0] count_value,
    output logic at_top,
    output logic zero_reached,
    output ctr16_dir_e dir
);

    logic [WIDTH-1:0] next_count;
    ctr16_dir_e next_dir;

    // Extremes of the current sequence
    assign at_top = count_value == top;
    assign zero_reached = count_value == '0;

    // ----------------------------------------------------------
    // Next count
    // ----------------------------------------------------------
    // Write wins; otherwise one step per tick, turning at the ends in dual slope, clearing at top in single slope
    always_comb
    begin
        next_count = count_value;
        next_dir = dir;
        if (load)
        begin
            next_count = load_val;
        end
        else if (tick)
        begin
            if (!dual)
            begin
                next_dir = CTR16_UP;
                next_count = at_top ? '0 : count_value + 1'b1;
            end
            else if (dir == CTR16_UP && count_value >= top)
            begin
                next_dir = CTR16_DOWN;
                next_count = count_value - 1'b1;
            end
            else if (dir == CTR16_DOWN && zero_reached)
            begin
                next_dir = CTR16_UP;
                next_count = count_value + 1'b1;
            end
            else
            begin
                next_count = (dir == CTR16_UP) ? count_value + 1'b1 : count_value - 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            count_value <= '0;
            dir <= CTR16_UP;
        end
        else
        begin
            count_value <= next_count;
            dir <= next_dir;
        end
    end

endmodule : ctr16_count_core

// ### design/ctr16_unit.sv
// Counter unit top: byte-wide register port, shared latch, mode and flag
`timescale 1ns/100ps
module ctr16_unit
    import ctr16_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input ctr16_bus_s bus_req,
    output logic [7:0] rdata,
    input wire logic ext_clk_pin,
    input wire logic ovf_ack,
    output logic overflow_flag,
    output logic [15:0] count_value,
    output logic at_top,
    output logic zero_reached
);

    logic [7:0] control_reg_a;
    logic [7:0] control_reg_b;
    logic [7:0] temp;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [15:0] cap;
    logic [7:0] next_control_reg_a;
    logic [7:0] next_control_reg_b;
    logic [7:0] next_temp;
    logic [15:0] next_cmpa;
    logic [15:0] next_cmpb;
    logic [15:0] next_cap;
    logic [7:0] next_rdata;
    logic next_overflow_flag;
    logic [3:0] waveform_mode_field;
    logic [2:0] clock_select_field;
    ctr16_mode_s mode;
    logic timer_tick;
    logic cnt_load;
    logic ovf_event;
    logic rd_cnt_lo;
    logic wr_cnt_lo;
    ctr16_dir_e dir;

    // ----------------------------------------------------------
    // Mode and clock select fields
    // ----------------------------------------------------------
    // Mode bits live in two registers; decoded once for everyone
    assign waveform_mode_field = {control_reg_b[CTR16_WGM_HI_POS+:2], control_reg_a[CTR16_WGM_LO_POS+:2]};
    assign clock_select_field = control_reg_b[CTR16_CS_POS+:3];
    assign mode = ctr16_decode(waveform_mode_field, cmpa, cap);
    assign rd_cnt_lo = bus_req.rd && bus_req.addr == CTR16_ADDR_CNT_LO;
    assign wr_cnt_lo = bus_req.wr && bus_req.addr == CTR16_ADDR_CNT_LO;
    assign cnt_load = wr_cnt_lo;

    // ----------------------------------------------------------
    // Tick source and counter
    // ----------------------------------------------------------
    ctr16_tick_sel u_tick
    (
        .clk(clk),
        .resetn(resetn),
        .clock_select_field(clock_select_field),
        .ext_clk_pin(ext_clk_pin),
        .timer_tick(timer_tick)
    );

    // Whole word loads in one edge: latch as upper, bus as lower
    ctr16_count_core #(.WIDTH(16)) u_core
    (
        .clk(clk),
        .resetn(resetn),
        .tick(timer_tick),
        .load(cnt_load),
        .load_val({temp, bus_req.wdata}),
        .top(mode.top),
        .dual(mode.dual),
        .count_value(count_value),
        .at_top(at_top),
        .zero_reached(zero_reached),
        .dir(dir)
    );

    // ----------------------------------------------------------
    // Overflow point
    // ----------------------------------------------------------
    // Lost if a write lands on the same tick, since the write wins
    always_comb
    begin
        case (mode.ovf_at)
            CTR16_OVF_AT_MAX: ovf_event = timer_tick && !cnt_load && count_value == CTR16_MAX;
            CTR16_OVF_AT_TOP: ovf_event = timer_tick && !cnt_load && at_top;
            CTR16_OVF_AT_ZERO_REACHED: ovf_event = timer_tick && !cnt_load && zero_reached && dir == CTR16_DOWN;
            default: ovf_event = 1'b0;
        endcase
    end

    // ----------------------------------------------------------
    // Register writes, shared latch and flag
    // ----------------------------------------------------------
    // One latch for all 16-bit registers; high locations hit it
    always_comb
    begin
        next_control_reg_a = control_reg_a;
        next_control_reg_b = control_reg_b;
        next_temp = temp;
        next_cmpa = cmpa;
        next_cmpb = cmpb;
        next_cap = cap;
        next_overflow_flag = overflow_flag;
        if (bus_req.wr)
        begin
            case (bus_req.addr)
                CTR16_ADDR_CTL_A: next_control_reg_a = bus_req.wdata;
                CTR16_ADDR_CTL_B: next_control_reg_b = bus_req.wdata;
                CTR16_ADDR_CNT_HI, CTR16_ADDR_CMPA_HI, CTR16_ADDR_CMPB_HI,
                CTR16_ADDR_CAP_HI: next_temp = bus_req.wdata;
                CTR16_ADDR_CMPA_LO: next_cmpa = {temp, bus_req.wdata};
                CTR16_ADDR_CMPB_LO: next_cmpb = {temp, bus_req.wdata};
                CTR16_ADDR_CAP_LO:
                begin
                    // Capture is writable only while it defines top
                    if (mode.cap_is_top)
                    begin
                        next_cap = {temp, bus_req.wdata};
                    end
                end
                CTR16_ADDR_FLAG:
                begin
                    if (bus_req.wdata[CTR16_OVF_POS])
                    begin
                        next_overflow_flag = 1'b0;
                    end
                end
                default: next_temp = temp;
            endcase
        end
        else if (bus_req.rd)
        begin
            case (bus_req.addr)
                CTR16_ADDR_CNT_LO: next_temp = count_value[15:8];
                CTR16_ADDR_CAP_LO: next_temp = cap[15:8];
                default: next_temp = temp;
            endcase
        end
        if (ovf_ack)
        begin
            next_overflow_flag = 1'b0;
        end
        // Setting after clearing keeps a same-cycle event
        if (ovf_event)
        begin
            next_overflow_flag = 1'b1;
        end
    end

    // ----------------------------------------------------------
    // Read data
    // ----------------------------------------------------------
    // Registered one edge after the strobe; unmapped reads give zero
    always_comb
    begin
        next_rdata = CTR16_BYTE_RST;
        if (bus_req.rd)
        begin
            case (bus_req.addr)
                CTR16_ADDR_CTL_A: next_rdata = control_reg_a;
                CTR16_ADDR_CTL_B: next_rdata = control_reg_b;
                CTR16_ADDR_CNT_LO: next_rdata = count_value[7:0];
                CTR16_ADDR_CNT_HI: next_rdata = temp;
                CTR16_ADDR_CMPA_LO: next_rdata = cmpa[7:0];
                CTR16_ADDR_CMPA_HI: next_rdata = cmpa[15:8];
                CTR16_ADDR_CMPB_LO: next_rdata = cmpb[7:0];
                CTR16_ADDR_CMPB_HI: next_rdata = cmpb[15:8];
                CTR16_ADDR_CAP_LO: next_rdata = cap[7:0];
                CTR16_ADDR_CAP_HI: next_rdata = temp;
                CTR16_ADDR_FLAG: next_rdata = {7'h00, overflow_flag};
                default: next_rdata = CTR16_BYTE_RST;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            control_reg_a <= CTR16_BYTE_RST;
            control_reg_b <= CTR16_BYTE_RST;
            temp <= CTR16_BYTE_RST;
            cmpa <= CTR16_WORD_RST;
            cmpb <= CTR16_WORD_RST;
            cap <= CTR16_WORD_RST;
            overflow_flag <= 1'b0;
            rdata <= CTR16_BYTE_RST;
        end
        else
        begin
            control_reg_a <= next_control_reg_a;
            control_reg_b <= next_control_reg_b;
            temp <= next_temp;
            cmpa <= next_cmpa;
            cmpb <= next_cmpb;
            cap <= next_cap;
            overflow_flag <= next_overflow_flag;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    lo_read_latch_a: assert property (rd_cnt_lo |=> temp == $past(count_value[15:8]))
        else $error("latch missed counter upper byte on low read");
    lo_read_data_a: assert property (rd_cnt_lo |=> rdata == $past(count_value[7:0]))
        else $error("low read returned wrong byte");
    lo_write_load_a: assert property (wr_cnt_lo |=> count_value == {$past(temp), $past(bus_req.wdata)})
        else $error("low write did not load whole word");
    hi_read_temp_a: assert property (bus_req.rd && bus_req.addr == CTR16_ADDR_CNT_HI
                                     |=> rdata == $past(temp) && $stable(temp))
        else $error("high read did not return latch");
    cmp_hi_direct_a: assert property (bus_req.rd && bus_req.addr == CTR16_ADDR_CMPA_HI
                                      |=> rdata == $past(cmpa[15:8]) && $stable(temp))
        else $error("compare high read went through latch");
    stop_hold_a: assert property (clock_select_field == 3'h0 && !cnt_load |=> $stable(count_value))
        else $error("counter moved while stopped");
    step_one_a: assert property (!cnt_load |=> count_value == $past(count_value)
                                 || count_value == $past(count_value) + 16'h0001
                                 || count_value == $past(count_value) - 16'h0001 || count_value == 16'h0000)
        else $error("counter stepped by more than one");
    top_clear_a: assert property (timer_tick && !cnt_load && at_top && !mode.dual
                                  |=> count_value == 16'h0000)
        else $error("single slope did not clear at top");
    ovf_set_a: assert property (ovf_event |=> overflow_flag ##1 overflow_flag
                                || $past(bus_req.wr && bus_req.addr == CTR16_ADDR_FLAG
                                         && bus_req.wdata[CTR16_OVF_POS]) || $past(ovf_ack))
        else $error("overflow flag not set");
    write_wins_a: assert property (wr_cnt_lo && timer_tick
                                   |=> count_value == {$past(temp), $past(bus_req.wdata)})
        else $error("tick overrode processor write");

    lo_read_c: cover property (rd_cnt_lo ##1 bus_req.rd && bus_req.addr == CTR16_ADDR_CNT_HI);
    hi_lo_write_c: cover property (bus_req.wr && bus_req.addr == CTR16_ADDR_CNT_HI ##1 wr_cnt_lo);
    ovf_c: cover property (ovf_event);
    turn_down_c: cover property (mode.dual && timer_tick && dir == CTR16_UP ##1 dir == CTR16_DOWN);

endmodule : ctr16_unit

// ### verification/ctr16_cpu_model.sv
// Processor core model: byte-wide accesses to the counter unit register port
`timescale 1ns/100ps
module ctr16_cpu_model
    import ctr16_pkg::*;
(
    input wire logic clk,
    output ctr16_bus_s bus_req,
    input wire logic [7:0] rdata
);
    // ----------------------------------------------------------
    // Byte access
    // ----------------------------------------------------------
    // Idle bus until the first access
    initial bus_req = '0;

    // One access: launched at a falling edge, released one cycle later.
    // An idle cycle is left between accesses so no strobe is set twice at once.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        bus_req = '{rd: ~w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        q = rdata;
        bus_req = '0;
    endtask : acc

    // ----------------------------------------------------------
    // Two-byte transfers
    // ----------------------------------------------------------
    // Upper byte first, then lower; nothing else runs in between
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, lo + 4'h1, v[15:8], q);
        acc(1'b1, lo, v[7:0], q);
    endtask : wr16

    // Lower byte first so the latch holds the matching upper byte
    task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
        acc(1'b0, lo, 8'h00, v[7:0]);
        acc(1'b0, lo + 4'h1, 8'h00, v[15:8]);
    endtask : rd16
endmodule : ctr16_cpu_model

// ### verification/ctr16_unit_tb.sv
// Self-checking bench for the 16-bit counter unit with a reference model
`timescale 1ns/100ps
module ctr16_unit_tb
    import ctr16_pkg::*;
;
    logic clk, resetn, ext_clk_pin, ovf_ack, overflow_flag, at_top, zero_reached;
    logic [7:0] rdata, q;
    logic [15:0] count_value, v, rb;
    ctr16_bus_s bus_req;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 32'h79cc;
    int m_top, m_dual, m_dir, cs, n, k;

    ctr16_unit ctr16_unit_inst (.clk(clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
        .ext_clk_pin(ext_clk_pin), .ovf_ack(ovf_ack), .overflow_flag(overflow_flag),
        .count_value(count_value), .at_top(at_top), .zero_reached(zero_reached));
    ctr16_cpu_model ctr16_cpu_model_inst (.clk(clk), .bus_req(bus_req), .rdata(rdata));

    // ----------------------------------------------------------
    // Clock, watchdog and reporting
    // ----------------------------------------------------------
    // 50 ns system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard, well above the longest sequence
    initial
    begin
        #2_000_000;
        timed_out();
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("mismatches=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish

    task automatic timed_out;
        num_errors++;
        tally_and_finish();
    endtask : timed_out

    task automatic w8(input logic [3:0] a, input logic [7:0] d);
        ctr16_cpu_model_inst.acc(1'b1, a, d, q);
    endtask : w8

    // ----------------------------------------------------------
    // Reference model of the count sequence
    // ----------------------------------------------------------
    // Waits (bounded) for the first tick, then predicts every step
    task automatic run_check(input int steps);
        int p;
        int j;
        p = count_value;
        for (j = 0; j < 8 && count_value === p[15:0]; j++)
            @(negedge clk);
        if (j == 8)
            timed_out();
        for (j = 0; j < steps; j++)
        begin
            if (m_dual != 0)
            begin
                if (p == m_top)
                    m_dir = 1;
                else if (p == 0)
                    m_dir = 0;
                p = (m_dir != 0) ? p - 1 : p + 1;
            end
            else
                p = (p == m_top) ? 0 : (p + 1) & 32'h0000_ffff;
            check(count_value, p);
            check(at_top, p == m_top);
            check(zero_reached, p == 0);
            @(negedge clk);
        end
    endtask : run_check

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        ext_clk_pin = 1'b0;
        ovf_ack = 1'b0;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        check(zero_reached, 1'b1);
        // Stopped counter is still writable and readable as a whole word
        v = 16'($random(seed));
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, v);
        check(count_value, v);
        ctr16_cpu_model_inst.rd16(CTR16_ADDR_CNT_LO, rb);
        check(rb, v);
        // One upper byte shared by a compare and the counter
        w8(CTR16_ADDR_CNT_HI, 8'h3c);
        w8(CTR16_ADDR_CMPA_LO, 8'h05);
        w8(CTR16_ADDR_CNT_LO, 8'h10);
        check(count_value, 16'h3c10);
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'h0000);
        ctr16_cpu_model_inst.acc(1'b0, CTR16_ADDR_CMPA_HI, 8'h00, q);
        check(q, 8'h3c);
        ctr16_cpu_model_inst.acc(1'b0, CTR16_ADDR_CNT_HI, 8'h00, q);
        check(q, 8'h00);
        // Clear on compare: top from compare A, mode 4
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CMPA_LO, 16'h0005);
        m_top = 5;
        m_dual = 0;
        w8(CTR16_ADDR_CTL_B, 8'h09);
        run_check(14);
        // Normal mode: write while ticking wins, then wrap through the maximum
        w8(CTR16_ADDR_CTL_B, 8'h01);
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'hfff0);
        check(count_value, 16'hfff0);
        m_top = 32'h0000_ffff;
        run_check(20);
        check(overflow_flag, 1'b1);
        ovf_ack = 1'b1;
        @(negedge clk);
        ovf_ack = 1'b0;
        check(overflow_flag, 1'b0);
        // Stop in mid-run: value holds
        w8(CTR16_ADDR_CTL_B, 8'h00);
        v = count_value;
        repeat (10) @(negedge clk);
        check(count_value, v);
        // Dual slope with fixed top 0x00ff, fresh reset so direction starts up
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check(zero_reached, 1'b1);
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'h00fb);
        w8(CTR16_ADDR_CTL_A, 8'h01);
        m_top = 255;
        m_dual = 1;
        m_dir = 0;
        w8(CTR16_ADDR_CTL_B, 8'h01);
        run_check(270);
        check(overflow_flag, 1'b1);
        // Flag seen on the register port and cleared by writing a one
        ctr16_cpu_model_inst.acc(1'b0, CTR16_ADDR_FLAG, 8'h00, q);
        check(q, 8'h01);
        w8(CTR16_ADDR_FLAG, 8'h01);
        check(overflow_flag, 1'b0);
        // Single slope to fixed top 0x00ff: wraps there and flags at top
        w8(CTR16_ADDR_CTL_B, 8'h09);
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'h00f8);
        m_dual = 0;
        run_check(12);
        check(overflow_flag, 1'b1);
        // Divide by eight: forty clocks hold exactly five ticks, any phase
        w8(CTR16_ADDR_CTL_A, 8'h00);
        w8(CTR16_ADDR_CTL_B, 8'h00);
        ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'h0000);
        w8(CTR16_ADDR_CTL_B, 8'h02);
        repeat (38) @(negedge clk);
        w8(CTR16_ADDR_CTL_B, 8'h00);
        check(count_value, 16'h0005);
        // External pin, falling then rising edge, random pulse widths
        for (cs = 6; cs < 8; cs++)
        begin
            w8(CTR16_ADDR_CTL_B, 8'h00);
            ctr16_cpu_model_inst.wr16(CTR16_ADDR_CNT_LO, 16'h0000);
            w8(CTR16_ADDR_CTL_B, cs[7:0]);
            n = 3 + ($unsigned($random(seed)) % 5);
            for (int p = 0; p < n; p++)
            begin
                k = 3 + ($unsigned($random(seed)) % 4);
                ext_clk_pin = 1'b1;
                repeat (k) @(negedge clk);
                ext_clk_pin = 1'b0;
                repeat (k) @(negedge clk);
            end
            repeat (6) @(negedge clk);
            check(count_value, n);
        end
        tally_and_finish();
    end
endmodule : ctr16_unit_tb
